// [ccmp_map.vh]
// Register map, field layout and reset values of the compare channel
`ifndef CCMP_MAP_VH
`define CCMP_MAP_VH
// Register byte offsets
`define CCMP_CTRL_OFF 12'h000
`define CCMP_CMPV_OFF 12'h004
`define CCMP_STAT_OFF 12'h008
`define CCMP_MASK_OFF 12'h00C
`define CCMP_CONV_OFF 12'h010
`define CCMP_INFO_OFF 12'h014
// Control register fields
`define CCMP_CTRL_MODE_LSB 0
`define CCMP_CTRL_MODE_MSB 3
`define CCMP_CTRL_TSEL_LSB 4
`define CCMP_CTRL_TSEL_MSB 5
`define CCMP_CTRL_DIR_BIT 6
`define CCMP_CTRL_WIDTH 7
// Status and mask bits
`define CCMP_STAT_MATCH_BIT 0
`define CCMP_STAT_TRIG_BIT 1
`define CCMP_STAT_WIDTH 2
// Converter control
`define CCMP_CONV_EN_BIT 0
// Mode codes
`define CCMP_MODE_OFF 4'h0
`define CCMP_MODE_TOGGLE 4'h2
`define CCMP_MODE_SET 4'h8
`define CCMP_MODE_CLEAR 4'h9
`define CCMP_MODE_SWINT 4'hA
`define CCMP_MODE_TRIG 4'hB
// Timer select codes
`define CCMP_TSEL_FIRST 2'h0
`define CCMP_TSEL_THIRD 2'h1
`define CCMP_TSEL_FIFTH 2'h2
// Reset values
`define CCMP_CTRL_RST 7'h40
`define CCMP_CMPV_RST 16'h0000
`define CCMP_STAT_RST 2'h0
`define CCMP_MASK_RST 2'h0
`endif

// [ccmp_match.v]
// Timer selection and rising-edge equality detector
`timescale 1ns/100ps
`include "ccmp_map.vh"
module ccmp_match (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Timers and compare value
  input wire [15:0] timer1_count,
  input wire [15:0] timer3_count,
  input wire [15:0] timer5_count,
  input wire [1:0] timer_sel,
  input wire [15:0] compare_value,
  input wire arm,
  // Result
  output wire match_pulse,
  output wire [15:0] selected_count
);
  reg [15:0] sel_cnt;
  reg eq_prev_reg;
  wire eq;

  always @* begin
    case (timer_sel)
      `CCMP_TSEL_FIRST: sel_cnt = timer1_count;
      `CCMP_TSEL_THIRD: sel_cnt = timer3_count;
      `CCMP_TSEL_FIFTH: sel_cnt = timer5_count;
      default: sel_cnt = timer1_count;
    endcase
  end
  assign selected_count = sel_cnt;

  // Full-width equality, one timer per channel
  assign eq = arm && (sel_cnt == compare_value);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_prev_reg <= 1'b0;
    end else begin
      eq_prev_reg <= eq;
    end
  end
  // Fire once on entry, not while timer sits on the value
  assign match_pulse = eq && !eq_prev_reg;
endmodule

// [ccmp_pin.v]
// Compare output latch and fuse-steered pin mux
`timescale 1ns/100ps
module ccmp_pin (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Actions
  input wire do_set,
  input wire do_clear,
  input wire do_toggle,
  input wire force_low,
  input wire drive_pin,
  input wire pin_direction_bit,
  input wire output_pin_select_fuse,
  // Pins
  output reg pin_a_out,
  output reg pin_a_oe,
  output reg pin_b_out,
  output reg pin_b_oe,
  output wire latch_level
);
  reg latch_reg;
  wire oe;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= 1'b0;
    end else if (force_low) begin
      latch_reg <= 1'b0;
    end else if (do_set) begin
      latch_reg <= 1'b1;
    end else if (do_clear) begin
      latch_reg <= 1'b0;
    end else if (do_toggle) begin
      latch_reg <= !latch_reg;
    end
  end
  assign latch_level = latch_reg;

  // Pin driven only when direction bit cleared
  assign oe = drive_pin && !pin_direction_bit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe <= 1'b0;
    end else begin
      // Fuse picks which pin carries the output
      pin_a_out <= latch_reg && output_pin_select_fuse;
      pin_a_oe <= oe && output_pin_select_fuse;
      pin_b_out <= latch_reg && !output_pin_select_fuse;
      pin_b_oe <= oe && !output_pin_select_fuse;
    end
  end
endmodule

// [ccmp_unit.v]
// Compare channel top: APB registers, match actions, interrupt and trigger
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "ccmp_map.vh"

// Notes on behaviour
// - Compare full 16-bit compare value against full 16-bit selected timer count.
// - Timer is first, third or fifth timer, selected per channel.
// - A match performs one action picked by the 4-bit mode field.
// - Match flag sets in the same cycle the action applies.
// - Software-interrupt mode only flags; the latch is kept and the pin is released.
// - Writing zero to the whole control register forces the latch low.
// - A fuse bit in config byte three high selects the output pin.
// - Special event trigger starts conversion only when converter enabled.
// - Only the fifth standard channel offers the special event trigger.
// - Compare behaviour is the same for all five channels.
module ccmp_unit #(
  parameter CHANNEL_INDEX = 5
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Timers, same clock domain
  input wire [15:0] timer1_count,
  input wire [15:0] timer3_count,
  input wire [15:0] timer5_count,
  // Configuration fuse, static pin level
  input wire config_byte_three_high_pin,
  // Output pins
  output wire ccp_pin_a_out,
  output wire ccp_pin_a_oe,
  output wire ccp_pin_b_out,
  output wire ccp_pin_b_oe,
  // Converter and interrupt
  output reg conversion_start,
  output wire irq
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [`CCMP_CTRL_WIDTH-1:0] channel_control_reg;
  reg [15:0] compare_value_reg;
  reg [`CCMP_STAT_WIDTH-1:0] status_reg;
  reg [`CCMP_STAT_WIDTH-1:0] status_next;
  reg [`CCMP_STAT_WIDTH-1:0] mask_reg;
  reg converter_control_reg;
  reg fuse_meta_reg;
  reg fuse_sync_reg;
  reg force_low_reg;
  wire [3:0] channel_mode_field;
  wire [1:0] timer_sel;
  wire pin_direction_bit;
  wire converter_enable_bit;
  wire wr_en;
  wire rd_en;
  wire match_pulse;
  wire [15:0] selected_count;
  wire latch_level;
  wire mode_valid;
  wire has_trigger;
  wire do_set;
  wire do_clear;
  wire do_toggle;
  wire do_trig;
  wire drive_pin;

  assign channel_mode_field = channel_control_reg[`CCMP_CTRL_MODE_MSB:`CCMP_CTRL_MODE_LSB];
  assign timer_sel = channel_control_reg[`CCMP_CTRL_TSEL_MSB:`CCMP_CTRL_TSEL_LSB];
  assign pin_direction_bit = channel_control_reg[`CCMP_CTRL_DIR_BIT];
  assign converter_enable_bit = converter_control_reg;

  // Decoder reused for read mux and write strobes
  function is_reg;
    input [11:0] addr;
    input [11:0] off;
    begin
      is_reg = (addr == off);
    end
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !(is_reg(paddr, `CCMP_CTRL_OFF) || is_reg(paddr, `CCMP_CMPV_OFF) ||
    is_reg(paddr, `CCMP_STAT_OFF) || is_reg(paddr, `CCMP_MASK_OFF) ||
    is_reg(paddr, `CCMP_CONV_OFF) || is_reg(paddr, `CCMP_INFO_OFF));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_control_reg <= `CCMP_CTRL_RST;
      compare_value_reg <= `CCMP_CMPV_RST;
      mask_reg <= `CCMP_MASK_RST;
      converter_control_reg <= 1'b0;
      force_low_reg <= 1'b0;
    end else begin
      force_low_reg <= 1'b0;
      if (wr_en && is_reg(paddr, `CCMP_CTRL_OFF)) begin
        channel_control_reg <= pwdata[`CCMP_CTRL_WIDTH-1:0];
        // Whole-register zero clears the output latch
        force_low_reg <= (pwdata[`CCMP_CTRL_WIDTH-1:0] == {`CCMP_CTRL_WIDTH{1'b0}});
      end
      if (wr_en && is_reg(paddr, `CCMP_CMPV_OFF)) begin
        compare_value_reg <= pwdata[15:0];
      end
      if (wr_en && is_reg(paddr, `CCMP_MASK_OFF)) begin
        mask_reg <= pwdata[`CCMP_STAT_WIDTH-1:0];
      end
      if (wr_en && is_reg(paddr, `CCMP_CONV_OFF)) begin
        converter_control_reg <= pwdata[`CCMP_CONV_EN_BIT];
      end
    end
  end

  // Read data captured in setup, stable through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      if (is_reg(paddr, `CCMP_CTRL_OFF)) begin
        prdata <= {25'h0000000, channel_control_reg};
      end else if (is_reg(paddr, `CCMP_CMPV_OFF)) begin
        prdata <= {16'h0000, compare_value_reg};
      end else if (is_reg(paddr, `CCMP_STAT_OFF)) begin
        prdata <= {30'h0000000, status_reg};
      end else if (is_reg(paddr, `CCMP_MASK_OFF)) begin
        prdata <= {30'h0000000, mask_reg};
      end else if (is_reg(paddr, `CCMP_CONV_OFF)) begin
        prdata <= {31'h0000000, converter_control_reg};
      end else if (is_reg(paddr, `CCMP_INFO_OFF)) begin
        prdata <= {14'h0000, fuse_sync_reg, latch_level, selected_count};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Fuse synchroniser
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_meta_reg <= 1'b0;
      fuse_sync_reg <= 1'b0;
    end else begin
      fuse_meta_reg <= config_byte_three_high_pin;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // ----------------------------------------
  // Match detection and action decode
  // ----------------------------------------
  // Compare path is identical for every channel index
  assign mode_valid = (channel_mode_field == `CCMP_MODE_TOGGLE) || (channel_mode_field == `CCMP_MODE_SET) ||
    (channel_mode_field == `CCMP_MODE_CLEAR) || (channel_mode_field == `CCMP_MODE_SWINT) ||
    (channel_mode_field == `CCMP_MODE_TRIG);
  assign has_trigger = (CHANNEL_INDEX == 5);

  ccmp_match u_match (
    .pclk(pclk),
    .presetn(presetn),
    .timer1_count(timer1_count),
    .timer3_count(timer3_count),
    .timer5_count(timer5_count),
    .timer_sel(timer_sel),
    .compare_value(compare_value_reg),
    .arm(mode_valid),
    .match_pulse(match_pulse),
    .selected_count(selected_count)
  );

  // Exactly one action per match
  assign do_toggle = match_pulse && (channel_mode_field == `CCMP_MODE_TOGGLE);
  assign do_set = match_pulse && (channel_mode_field == `CCMP_MODE_SET);
  assign do_clear = match_pulse && (channel_mode_field == `CCMP_MODE_CLEAR);
  assign do_trig = match_pulse && (channel_mode_field == `CCMP_MODE_TRIG) && has_trigger;
  // Software-interrupt mode releases the pin
  assign drive_pin = (channel_mode_field == `CCMP_MODE_TOGGLE) || (channel_mode_field == `CCMP_MODE_SET) ||
    (channel_mode_field == `CCMP_MODE_CLEAR);

  ccmp_pin u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .do_set(do_set),
    .do_clear(do_clear),
    .do_toggle(do_toggle),
    .force_low(force_low_reg),
    .drive_pin(drive_pin),
    .pin_direction_bit(pin_direction_bit),
    .output_pin_select_fuse(fuse_sync_reg),
    .pin_a_out(ccp_pin_a_out),
    .pin_a_oe(ccp_pin_a_oe),
    .pin_b_out(ccp_pin_b_out),
    .pin_b_oe(ccp_pin_b_oe),
    .latch_level(latch_level)
  );

  // ----------------------------------------
  // Trigger and interrupt
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_start <= 1'b0;
    end else begin
      // Converter must be enabled
      conversion_start <= do_trig && converter_enable_bit;
    end
  end

  // Set wins over write-one-to-clear
  always @* begin
    status_next = status_reg;
    if (wr_en && is_reg(paddr, `CCMP_STAT_OFF)) begin
      status_next = status_next & ~pwdata[`CCMP_STAT_WIDTH-1:0];
    end
    if (match_pulse) begin
      status_next[`CCMP_STAT_MATCH_BIT] = 1'b1;
    end
    if (do_trig) begin
      status_next[`CCMP_STAT_TRIG_BIT] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `CCMP_STAT_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  assign irq = |(status_reg & mask_reg);
endmodule

// [ccmp_timer_model.sv]
// Behavioural model of the three timers feeding the compare channel
`timescale 1ns/100ps
module ccmp_timer_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Load request from the bench
  input wire load,
  input wire [1:0] load_sel,
  input wire [15:0] load_val,
  // Counts
  output reg [15:0] t1,
  output reg [15:0] t3,
  output reg [15:0] t5
);
  // Unselected timers differ only in the top bit, so a short compare is caught
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1 <= 16'h0000;
      t3 <= 16'h0000;
      t5 <= 16'h0000;
    end else if (load) begin
      t1 <= (load_sel == 2'h0) ? load_val : load_val ^ 16'h8000;
      t3 <= (load_sel == 2'h1) ? load_val : load_val ^ 16'h8000;
      t5 <= (load_sel == 2'h2) ? load_val : load_val ^ 16'h8000;
    end
  end
endmodule

// [ccmp_unit_props.sv]
// Concurrent checks on the compare channel ports
`timescale 1ns/100ps
module ccmp_unit_props #(
  parameter CHANNEL_INDEX = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [15:0] timer1_count,
  input wire [15:0] timer3_count,
  input wire [15:0] timer5_count,
  input wire config_byte_three_high_pin,
  input wire ccp_pin_a_out,
  input wire ccp_pin_a_oe,
  input wire ccp_pin_b_out,
  input wire ccp_pin_b_oe,
  input wire conversion_start,
  input wire irq
);
  reg [3:0] quiet_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since any input that could move the outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      quiet_reg <= 4'h0;
    else if (psel || $changed({timer1_count, timer3_count, timer5_count, config_byte_three_high_pin}))
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
      quiet_reg <= quiet_reg + 4'h1;
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_trig;
    conversion_start ##1 !conversion_start;
  endsequence
  chk_ready_always: assert property (pready) else $error("pready low");
  chk_err_decode: assert property (s_access ##0 paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h014))
    else $error("pslverr wrong for address");
  chk_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("pslverr outside access");
  chk_trig_pulse: assert property (conversion_start |-> s_trig) else $error("trigger longer than one cycle");
  chk_trig_channel: assert property (conversion_start |-> CHANNEL_INDEX == 5)
    else $error("trigger on wrong channel");
  chk_trig_cause: assert property (conversion_start |-> quiet_reg < 4'h3)
    else $error("trigger without a new match");
  chk_oe_onehot: assert property (!(ccp_pin_a_oe && ccp_pin_b_oe))
    else $error("both pins driven");
  chk_fuse_pin: assert property ($stable(config_byte_three_high_pin) [*4] ##0 ccp_pin_a_oe |-> config_byte_three_high_pin)
    else $error("pin A driven against fuse");
  chk_hold_quiet: assert property (quiet_reg > 4'h5 |-> $stable({ccp_pin_a_out, ccp_pin_b_out, irq}))
    else $error("output moved with no new match");
endmodule
bind ccmp_unit ccmp_unit_props #(.CHANNEL_INDEX(CHANNEL_INDEX)) i_ccmp_unit_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .timer1_count(timer1_count), .timer3_count(timer3_count), .timer5_count(timer5_count),
  .config_byte_three_high_pin(config_byte_three_high_pin), .ccp_pin_a_out(ccp_pin_a_out),
  .ccp_pin_a_oe(ccp_pin_a_oe), .ccp_pin_b_out(ccp_pin_b_out), .ccp_pin_b_oe(ccp_pin_b_oe),
  .conversion_start(conversion_start), .irq(irq));

// [test_ccmp_unit.sv]
// Self-checking bench for the compare channel
`timescale 1ns/100ps
`include "ccmp_map.vh"
module test_ccmp_unit;
  reg pclk = 1'h0;
  reg presetn = 1'h0;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg load = 1'h0;
  reg [1:0] load_sel = 2'h0;
  reg [15:0] load_val = 16'h0;
  reg fuse = 1'h1;
  wire pready, pslverr, a_out, a_oe, b_out, b_oe, conv, irq;
  wire [31:0] prdata;
  wire [15:0] t1, t3, t5;
  reg [31:0] rd;
  reg err, lat, ce;
  reg [3:0] m;
  reg [1:0] t;
  reg [15:0] v;
  integer seed, mismatches, checks_done, cs_count, n0, i;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (conv === 1'h1) cs_count <= cs_count + 1;
  ccmp_timer_model i_ccmp_timer_model (.pclk(pclk), .presetn(presetn), .load(load), .load_sel(load_sel),
    .load_val(load_val), .t1(t1), .t3(t3), .t5(t5));
  ccmp_unit i_ccmp_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer1_count(t1), .timer3_count(t3), .timer5_count(t5), .config_byte_three_high_pin(fuse),
    .ccp_pin_a_out(a_out), .ccp_pin_a_oe(a_oe), .ccp_pin_b_out(b_out), .ccp_pin_b_oe(b_oe),
    .conversion_start(conv), .irq(irq));
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // Let the access edge settle before outputs are compared
      @(negedge pclk);
    end
  endtask
  task ld(input [1:0] s, input [15:0] d);
    begin
      @(posedge pclk);
      load <= 1'h1;
      load_sel <= s;
      load_val <= d;
      @(posedge pclk);
      load <= 1'h0;
    end
  endtask
  task cmp(input [8*10-1:0] nm, input [31:0] e, input [31:0] s);
    begin
      checks_done = checks_done + 1;
      if (e !== s) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  function [3:0] mode_of(input integer k);
    case (k)
      0: mode_of = `CCMP_MODE_TOGGLE;
      1: mode_of = `CCMP_MODE_SET;
      2: mode_of = `CCMP_MODE_CLEAR;
      3: mode_of = `CCMP_MODE_SWINT;
      default: mode_of = `CCMP_MODE_TRIG;
    endcase
  endfunction
  function next_lat(input [3:0] md, input l);
    case (md)
      `CCMP_MODE_TOGGLE: next_lat = ~l;
      `CCMP_MODE_SET: next_lat = 1'h1;
      `CCMP_MODE_CLEAR: next_lat = 1'h0;
      default: next_lat = l;
    endcase
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = 32;
    mismatches = 0;
    checks_done = 0;
    cs_count = 0;
    lat = 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `CCMP_CTRL_OFF, 32'h0);
    cmp("ctrl rst", {25'h0, `CCMP_CTRL_RST}, rd);
    cmp("pins idle", 32'h0, {a_oe, b_oe});
    apb(1'h0, 12'h018, 32'h0);
    cmp("unmapped", 32'h1, {rd[30:0], err});
    apb(1'h1, `CCMP_MASK_OFF, 32'h1);
    $display("test reset done");
    for (i = 0; i < 15; i = i + 1) begin
      m = mode_of(i % 5);
      t = i / 5;
      v = $random(seed);
      ce = $random(seed);
      fuse <= $random(seed);
      apb(1'h1, `CCMP_CONV_OFF, {31'h0, ce});
      ld(2'h3, v);
      apb(1'h1, `CCMP_CMPV_OFF, {16'h0, v});
      apb(1'h1, `CCMP_CTRL_OFF, {26'h0, t, m});
      apb(1'h1, `CCMP_STAT_OFF, 32'h3);
      cmp("irq near", 32'h0, irq);
      n0 = cs_count;
      ld(t, v);
      // Timer held on the match value to expose repeated actions
      repeat (5) @(posedge pclk);
      lat = next_lat(m, lat);
      cmp("irq match", 32'h1, irq);
      apb(1'h0, `CCMP_INFO_OFF, 32'h0);
      cmp("latch", lat, rd[16]);
      cmp("pin", lat, fuse ? a_out : b_out);
      if (m != `CCMP_MODE_SWINT && m != `CCMP_MODE_TRIG) begin
        cmp("pin oe", fuse ? 32'h2 : 32'h1, {a_oe, b_oe});
      end else begin
        cmp("pin rel", 32'h0, {a_oe, b_oe});
      end
      cmp("trigger", m == `CCMP_MODE_TRIG && ce, cs_count - n0);
      apb(1'h1, `CCMP_STAT_OFF, 32'h3);
      cmp("irq clear", 32'h0, irq);
      if ($random(seed) & 1) begin
        apb(1'h1, `CCMP_CTRL_OFF, 32'h0);
        lat = 1'h0;
        apb(1'h0, `CCMP_INFO_OFF, 32'h0);
        cmp("force low", 32'h0, rd[16]);
      end else
        apb(1'h1, `CCMP_CTRL_OFF, {25'h0, 1'h1, t, 4'h0});
      $display("test %0d done", i);
    end
    complete_run;
  end
  initial begin
    #100000;
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule
